/* hdl/sfr_consts.vh */
/*
 * constants for the single-wire frame receiver: capture clock, nibble
 * timing, buffer slots, error codes and crc settings.
 * assumes it is included by its bare name from the design files.
 */
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

// capture counting clock and system clock, in kHz
`define SFR_CAP_CLK_KHZ     40000
`define SFR_SYS_CLK_KHZ     200000
// system clocks per capture tick
`define SFR_CAP_DIV         (`SFR_SYS_CLK_KHZ / `SFR_CAP_CLK_KHZ)

// default tick length in capture counts (3 us at 40 MHz)
`define SFR_TICK_CNT        120
// sync pulse is 56 ticks, nibble pulse is 12 + value ticks
`define SFR_SYNC_TICKS      56
`define SFR_NIB_BASE_TICKS  12

// buffer slot indices
`define SFR_SLOT_STATUS     4'h1
`define SFR_SLOT_DATA1      4'h2
`define SFR_SLOT_CRC        4'h8
`define SFR_SLOTS           10

// error status codes
`define SFR_ERR_NONE        16'h0000
`define SFR_ERR_CRC         16'h000A

// crc seed, polynomial x^4+x^3+x^2+1 low bits
`define SFR_CRC_SEED        4'h5
`define SFR_CRC_POLY        4'hD

`endif

/* hdl/sfr_nibble_mem.v */
/*
 * small nibble store: one write port, one read port, registered read.
 * assumes writes and reads come from the same clock domain.
 */
`timescale 1ns/100ps
module sfr_nibble_mem #(
	parameter DEPTH = 10,
	parameter AW    = 4
) (
	// clock
	input  wire          i_clk,
	// write side
	input  wire          i_wr_en,
	input  wire [AW-1:0] i_wr_addr,
	input  wire [3:0]    i_wr_data,
	// read side
	input  wire [AW-1:0] i_rd_addr,
	output reg  [3:0]    o_rd_data
);

	reg [3:0] mem [0:DEPTH-1];

	always @(posedge i_clk) begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
		o_rd_data <= mem[i_rd_addr];
	end

endmodule // sfr_nibble_mem

/* hdl/sfr_frame_receiver.v */
/*
 * receiver for single-edge nibble frames on one input line: timestamps
 * falling edges with a 40 MHz capture count, classifies each period as
 * pause, sync, status, data or crc nibble, stores nibbles and checks crc.
 * assumes the serial line is asynchronous to i_clk and idles high.
 */
//
// Summary of operation
// [R1] timestamp falling edges with 40 MHz counter
// [R2] each measured period is one frame element
// [R3] pulse event per element, in frame order
// [R4] frame done only after crc checked
// [R5] nibble values stored as 0 to 15
// [R6] ten-slot buffer, status, data, crc slots
// [R7] 16-bit error status, 000A on crc mismatch
// [R8] compute 4-bit crc, compare with received
// [R9] crc covers data nibbles 1 to 6
// [R10] poly x4+x3+x2+1, seed 0101, zero augment
`timescale 1ns/100ps
`include "sfr_consts.vh"
module sfr_frame_receiver #(
	parameter CNT_W    = 16,
	parameter TICK_CNT = `SFR_TICK_CNT
) (
	// clock and reset
	input  wire             i_clk,
	input  wire             i_reset_n,
	// serial line
	input  wire             i_sent_serial_input,
	// per-pulse report
	output reg              o_pulse_measured_event,
	output reg  [CNT_W-1:0] o_captured_period_value,
	output reg  [3:0]       o_pulse_kind,
	// frame report
	output reg              o_frame_done_notify,
	output reg  [15:0]      o_rx_error_status,
	// nibble buffer read port
	input  wire [3:0]       i_rd_slot,
	output wire [3:0]       o_rx_nibble_buffer
);

	// element kinds, one-hot
	localparam [3:0] K_PAUSE = 4'h1;
	localparam [3:0] K_SYNC  = 4'h2;
	localparam [3:0] K_NIB   = 4'h4;
	localparam [3:0] K_CRC   = 4'h8;

	// integer arithmetic first, then cut to the target width on purpose
	localparam integer DIV_LAST_I = `SFR_CAP_DIV - 1;
	localparam integer SYNC_LO_I  = (`SFR_SYNC_TICKS - 1) * TICK_CNT;
	localparam integer SYNC_HI_I  = (`SFR_SYNC_TICKS + 1) * TICK_CNT;
	localparam integer NIB_BASE_I =
		`SFR_NIB_BASE_TICKS * TICK_CNT - TICK_CNT / 2;
	localparam [2:0]       DIV_LAST = DIV_LAST_I[2:0];
	localparam [CNT_W-1:0] SYNC_LO  = SYNC_LO_I[CNT_W-1:0];
	localparam [CNT_W-1:0] SYNC_HI  = SYNC_HI_I[CNT_W-1:0];
	localparam [CNT_W-1:0] NIB_BASE = NIB_BASE_I[CNT_W-1:0];

	// one crc step: multiply by x^4 modulo the polynomial, then add the
	// nibble; a trailing zero nibble finishes the augmentation
	function [3:0] crc_step;
		input [3:0] crc;
		input [3:0] nib;
		reg   [3:0] c;
		integer     k;
		begin
			c = crc;
			for (k = 0; k < 4; k = k + 1) begin
				if (c[3])
					c = {c[2:0], 1'b0} ^ `SFR_CRC_POLY;
				else
					c = {c[2:0], 1'b0};
			end
			crc_step = c ^ nib;
		end
	endfunction

	// rounded nibble value from period, clamped to 0..15
	function [3:0] period_to_nib;
		input [CNT_W-1:0] per;
		reg   [CNT_W-1:0] rem;
		integer           n;
		begin
			period_to_nib = 4'h0;
			if (per > NIB_BASE) begin
				rem = per - NIB_BASE;
				for (n = 1; n < 16; n = n + 1)
					if (rem >= n * TICK_CNT)
						period_to_nib = n[3:0];
			end
		end
	endfunction

	// line synchroniser; only sync2 and beyond are looked at
	reg sync1;
	reg sync2;
	reg sync3;
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= i_sent_serial_input;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	wire fall = sync3 & ~sync2;

	// [R1] 40 MHz capture count
	reg [2:0]       div;
	reg [CNT_W-1:0] cap_cnt;
	reg [CNT_W-1:0] last_cap;
	reg             armed;
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div     <= 3'h0;
			cap_cnt <= {CNT_W{1'b0}};
		end else if (div == DIV_LAST) begin
			div     <= 3'h0;
			cap_cnt <= cap_cnt + 1'b1;
		end else begin
			div <= div + 1'b1;
		end
	end

	// [R2] period between successive captures
	wire [CNT_W-1:0] period   = cap_cnt - last_cap;
	wire             is_sync  = (period >= SYNC_LO) &&
		(period <= SYNC_HI);
	wire [3:0]       nib_val  = period_to_nib(period);

	// frame sequence: position 0 waits for sync, 1..7 nibbles, 8 crc
	reg  [3:0]  pos;
	reg  [3:0]  crc;
	reg         wr_en;
	reg  [3:0]  wr_slot;
	reg  [3:0]  wr_data;
	reg  [3:0]  next_pos;
	reg  [3:0]  kind;

	// position: 0 idle/pause, 1 status, 2..7 data, 8 crc
	always @* begin
		next_pos = pos;
		kind     = K_PAUSE;
		if (is_sync) begin
			kind     = K_SYNC;
			next_pos = `SFR_SLOT_STATUS;
		end else if (pos == 4'h0) begin
			kind = K_PAUSE;
		end else if (pos == `SFR_SLOT_CRC) begin
			kind     = K_CRC;
			next_pos = 4'h0;
		end else begin
			kind     = K_NIB;
			next_pos = pos + 4'h1;
		end
	end

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			last_cap                <= {CNT_W{1'b0}};
			armed                   <= 1'b0;
			pos                     <= 4'h0;
			crc                     <= `SFR_CRC_SEED;
			wr_en                   <= 1'b0;
			wr_slot                 <= 4'h0;
			wr_data                 <= 4'h0;
			o_pulse_measured_event  <= 1'b0;
			o_captured_period_value <= {CNT_W{1'b0}};
			o_pulse_kind            <= 4'h0;
			o_frame_done_notify     <= 1'b0;
			o_rx_error_status       <= `SFR_ERR_NONE;
		end else begin
			wr_en                  <= 1'b0;
			o_pulse_measured_event <= 1'b0;
			o_frame_done_notify    <= 1'b0;
			if (fall) begin
				last_cap <= cap_cnt;
				armed    <= 1'b1;
			end
			// first edge only starts timing; no period exists yet
			if (fall && armed) begin
				// [R3] one event per element
				o_pulse_measured_event  <= 1'b1;
				o_captured_period_value <= period;
				o_pulse_kind            <= kind;
				pos                     <= next_pos;
				if (kind == K_SYNC)
					crc <= `SFR_CRC_SEED;
				if (kind == K_NIB || kind == K_CRC) begin
					// [R5] [R6] store nibble in its slot
					wr_en   <= 1'b1;
					wr_slot <= pos;
					wr_data <= nib_val;
				end
				// [R9] data nibbles only feed crc
				if (kind == K_NIB && pos >= `SFR_SLOT_DATA1)
					crc <= crc_step(crc, nib_val);
				if (kind == K_CRC) begin
					// [R8] [R10] zero augment then compare
					// [R7] error code from crc check
					if (crc_step(crc, 4'h0) == nib_val)
						o_rx_error_status <= `SFR_ERR_NONE;
					else
						o_rx_error_status <= `SFR_ERR_CRC;
				end
			end
			// [R4] done one cycle after crc event, on the edge that stores crc
			if (wr_en && wr_slot == `SFR_SLOT_CRC)
				o_frame_done_notify <= 1'b1;
		end
	end

	sfr_nibble_mem #(
		.DEPTH (`SFR_SLOTS),
		.AW    (4)
	) u_mem (
		.i_clk     (i_clk),
		.i_wr_en   (wr_en),
		.i_wr_addr (wr_slot),
		.i_wr_data (wr_data),
		.i_rd_addr (i_rd_slot),
		.o_rd_data (o_rx_nibble_buffer)
	);

endmodule // sfr_frame_receiver

/* testbench/sfr_checker_properties.sv */
/* port checker for sfr_frame_receiver, bound to every instance.
   assumes the 200 MHz clock and TICK_CNT as set on the design. */
`timescale 1ns/100ps
module sfr_checker #(parameter TICK_CNT = 120) (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic        i_sent_serial_input,
	input wire logic        o_pulse_measured_event,
	input wire logic [15:0] o_captured_period_value,
	input wire logic [3:0]  o_pulse_kind,
	input wire logic        o_frame_done_notify,
	input wire logic [15:0] o_rx_error_status
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire crc_ev = o_pulse_measured_event && o_pulse_kind == 4'h8;
	// rounding margin of one tick on either side of the sync window
	wire [15:0] lo = 16'(54 * TICK_CNT);
	wire [15:0] hi = 16'(58 * TICK_CNT);
	a_event_single:
	assert property (o_pulse_measured_event |=> !o_pulse_measured_event)
		else $error("event longer than one cycle");
	a_kind_onehot:
	assert property (o_pulse_measured_event |-> $onehot(o_pulse_kind))
		else $error("pulse kind not one-hot");
	a_event_line_low:
	assert property (o_pulse_measured_event |-> !$past(i_sent_serial_input, 2))
		else $error("event without a falling edge");
	a_sync_window:
	assert property (o_pulse_measured_event && o_pulse_kind == 4'h2
		|-> o_captured_period_value >= lo && o_captured_period_value <= hi)
		else $error("sync period out of window");
	a_done_after_crc:
	assert property (o_frame_done_notify |-> $past(crc_ev))
		else $error("frame done without crc pulse");
	a_crc_then_done:
	assert property (crc_ev |=> o_frame_done_notify)
		else $error("crc pulse without frame done");
	a_err_codes:
	assert property (o_rx_error_status == 16'h0000
		|| o_rx_error_status == 16'h000A)
		else $error("illegal error code");
	a_err_only_crc:
	assert property ($changed(o_rx_error_status) |-> crc_ev)
		else $error("error status changed off crc pulse");
endmodule // sfr_checker
bind sfr_frame_receiver sfr_checker #(.TICK_CNT(TICK_CNT)) u_chk (
	.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_sent_serial_input(i_sent_serial_input),
	.o_pulse_measured_event(o_pulse_measured_event),
	.o_captured_period_value(o_captured_period_value),
	.o_pulse_kind(o_pulse_kind),
	.o_frame_done_notify(o_frame_done_notify),
	.o_rx_error_status(o_rx_error_status));

/* testbench/sfr_tx_model.sv */
/* behavioural transmitter: sync, status, six data, crc, then pause.
   assumes i_nibs is stable from i_go until the pause ends. */
`timescale 1ns/100ps
module sfr_tx_model #(parameter TICK_NS = 200) (
	input  wire logic        i_go,
	input  wire logic [31:0] i_nibs,
	output logic             o_line
);
	initial o_line = 1'b1;
	task pulse(input int t);
		o_line = 1'b0;
		#(5 * TICK_NS) o_line = 1'b1;
		#((t - 5) * TICK_NS);
	endtask
	always @(posedge i_go) begin
		pulse(56);
		for (int i = 7; i >= 0; i--)
			pulse(12 + i_nibs[4*i+:4]);
		// the pause start closes the crc pulse; line then idles high
		pulse(20);
	end
endmodule // sfr_tx_model

/* testbench/sfr_frame_receiver_tb.sv */
/* self-checking bench for sfr_frame_receiver with a transmitter model.
   assumes a 200 MHz clock and a shortened tick of 8 counts. */
`timescale 1ns/100ps
module sfr_frame_receiver_tb;
	localparam TICK = 8;
	logic        i_clk, i_reset_n, line, go, ev, done;
	logic [31:0] nibs;
	logic [15:0] err, per;
	logic [3:0]  slot, rd, kind;
	int          n_mismatch, compares, cyc, n_ev;
	sfr_frame_receiver #(.TICK_CNT(TICK)) uut (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_sent_serial_input(line),
		.o_pulse_measured_event(ev), .o_captured_period_value(per),
		.o_pulse_kind(kind), .o_frame_done_notify(done),
		.o_rx_error_status(err), .i_rd_slot(slot),
		.o_rx_nibble_buffer(rd));
	sfr_tx_model #(.TICK_NS(TICK * 25)) u_tx (.i_go(go), .i_nibs(nibs),
		.o_line(line));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (ev === 1'b1) n_ev++;
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	function automatic [3:0] crc4(input [23:0] d);
		logic [3:0] c;
		c = 4'h5;
		for (int i = 6; i >= 0; i--) begin
			repeat (4) c = c[3] ? {c[2:0], 1'b0} ^ 4'hD : {c[2:0], 1'b0};
			c = c ^ (i > 0 ? d[4*i-1-:4] : 4'h0);
		end
		return c;
	endfunction
	task cmp(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask
	task send(input [27:0] sd, input logic bad, input int n_exp);
		int e0;
		logic seen;
		e0 = n_ev;
		seen = 1'b0;
		nibs = {sd, crc4(sd[23:0]) ^ {3'b0, bad}};
		@(negedge i_clk) go = 1'b1;
		@(negedge i_clk) go = 1'b0;
		repeat (20000) @(negedge i_clk) if (done === 1'b1) begin
			seen = 1'b1;
			break;
		end
		cmp("frame done", 16'h0001, {15'h0, seen});
		cmp("events", 16'(n_exp), 16'(n_ev - e0));
		cmp("error", bad ? 16'h000A : 16'h0000, err);
		cmp("crc kind", 16'h0008, 16'(kind));
		cmp("crc period", 16'((12 + nibs[3:0]) * TICK), per);
		for (int s = 1; s <= 8; s++) begin
			@(negedge i_clk) slot = 4'(s);
			@(negedge i_clk) cmp("slot", 16'(nibs[4*(8-s)+:4]), 16'(rd));
		end
		// let the model finish its pause before the next frame
		repeat (900) @(negedge i_clk);
	endtask
	task t_good;
		send(28'h35A1C96, 1'b0, 9);
		$display("test good frame finished");
	endtask
	task t_bad;
		send(28'h7123456, 1'b1, 10);
		$display("test crc error finished");
	endtask
	task t_edges;
		send(28'hF0F00FF, 1'b0, 10);
		$display("test extreme nibbles finished");
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		i_reset_n = 1'b0;
		go = 1'b0;
		nibs = 32'h0;
		slot = 4'h0;
		repeat (6) @(negedge i_clk);
		i_reset_n = 1'b1;
		t_good();
		t_bad();
		t_edges();
		stop_test();
	end
endmodule // sfr_frame_receiver_tb
